// *** verilog/acs_consts.svh ***
// Constants of the automatic cycle run/stop controller
// Behaviour
// - Diagnostic flags 020..025 name the drop cause
// - Either emergency stop input low stops operation
// - External reset request ends automatic operation
// - Reset-and-rewind request resets and rewinds program
// - Panel reset key resets automatic operation
// - Servo alarm forces the reset state
// - Automatic-to-manual mode change enters feed hold
// - Feed-hold input low enters feed hold
// - Decode three mode bits into seven modes
// - Single block stops after each block
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ACS_OFS_CMD 8'h00
`define ACS_OFS_STATUS 8'h04
`define ACS_OFS_DIAG 8'h08
`define ACS_OFS_IRQ_STAT 8'h0C
`define ACS_OFS_IRQ_MASK 8'h10

// ****************************************
// Field positions
// ****************************************
`define ACS_CMD_START 0
`define ACS_CMD_RESET_KEY 1
`define ACS_SIG_ESTOP 4
`define ACS_SIG_EXT_RESET 7
`define ACS_SIG_RESET_REWIND 6
`define ACS_SIG_FEED_HOLD 5
`define ACS_SIG_SINGLE_BLOCK 1
`define ACS_IRQ_DROP 0
`define ACS_IRQ_REWIND 1

// ****************************************
// Diagnostic entry numbers and widths
// ****************************************
`define ACS_DIAG_FIRST 20
`define ACS_DIAG_LAST 25
`define ACS_DIAG_W 6
`define ACS_IRQ_W 2

// ****************************************
// Reset values
// ****************************************
`define ACS_RST_DIAG 6'h00
`define ACS_RST_IRQ 2'h0

// Answer codes of the register bus
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2

`endif

// *** verilog/acs_pkg.sv ***
// Types of the automatic cycle run/stop controller
package acs_pkg;

  // Run state of automatic operation
  typedef enum logic [1:0] {
    ACS_RESET,
    ACS_RUN,
    ACS_HOLD,
    ACS_BLOCK_STOP
  } acs_state_t;

  // Decoded operating mode
  typedef enum logic [2:0] {
    ACS_MODE_MDI,
    ACS_MODE_AUTO,
    ACS_MODE_EDIT,
    ACS_MODE_JOG,
    ACS_MODE_HANDLE,
    ACS_MODE_TEACH_JOG,
    ACS_MODE_TEACH_HANDLE
  } acs_mode_t;

endpackage

// *** verilog/acs_top.sv ***
// Automatic cycle run/stop control with AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Machine and controller signal bytes
  input wire logic [7:0] machine_in_byte,
  input wire logic [7:0] ctrl_signal_byte,
  input wire logic mode_sel_high,
  input wire logic mode_sel_mid,
  input wire logic mode_sel_low,
  input wire logic servo_alarm,
  input wire logic block_done,
  // Indicators
  output logic cycle_running_lamp,
  output logic feed_hold_lamp,
  output logic program_rewind,
  output logic irq
);

  // ****************************************
  // Parameter check
  // ****************************************
  // Decode reads the low eight address bits, so narrower buses cannot work
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  // ****************************************
  // State
  // ****************************************
  acs_pkg::acs_state_t state;
  acs_pkg::acs_state_t next_state;
  acs_pkg::acs_mode_t mode;
  logic prev_auto;
  logic [`ACS_DIAG_W-1:0] diag;
  logic [`ACS_IRQ_W-1:0] irq_stat;
  logic [`ACS_IRQ_W-1:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ****************************************
  // Mode decoding
  // ****************************************
  wire logic [2:0] mode_bits = {mode_sel_high, mode_sel_mid, mode_sel_low};

  // Three mode bits to operating mode
  always_comb
  begin
    unique case (mode_bits)
      3'h3: mode = acs_pkg::ACS_MODE_EDIT;
      3'h1: mode = acs_pkg::ACS_MODE_AUTO;
      3'h0: mode = acs_pkg::ACS_MODE_MDI;
      3'h4: mode = acs_pkg::ACS_MODE_JOG;
      3'h5: mode = acs_pkg::ACS_MODE_HANDLE;
      3'h7: mode = acs_pkg::ACS_MODE_TEACH_HANDLE;
      3'h6: mode = acs_pkg::ACS_MODE_TEACH_JOG;
      default: mode = acs_pkg::ACS_MODE_JOG;
    endcase
  end

  // Automatic group is edit, memory and manual data input
  wire logic mode_auto = (mode_bits == 3'h3) || (mode_bits == 3'h1) || (mode_bits == 3'h0);
  wire logic mode_runs = (mode_bits == 3'h1) || (mode_bits == 3'h0);

  // ****************************************
  // Register bus decode
  // ****************************************
  wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire logic wr_lane0 = w_strb[0];
  wire logic wr_cmd = wr_fire && wr_lane0 && (aw_addr[7:0] == `ACS_OFS_CMD);
  wire logic wr_irq_stat = wr_fire && wr_lane0 && (aw_addr[7:0] == `ACS_OFS_IRQ_STAT);
  wire logic wr_irq_mask = wr_fire && wr_lane0 && (aw_addr[7:0] == `ACS_OFS_IRQ_MASK);
  wire logic wr_mapped = (aw_addr[7:0] == `ACS_OFS_CMD) || (aw_addr[7:0] == `ACS_OFS_IRQ_STAT)
    || (aw_addr[7:0] == `ACS_OFS_IRQ_MASK);
  wire logic hi_addr_zero_w = (aw_addr >> 8) == '0;
  wire logic hi_addr_zero_r = (s_axi_araddr >> 8) == '0;
  wire logic [7:0] rd_ofs = s_axi_araddr[7:0];
  wire logic rd_fire = s_axi_arvalid && s_axi_arready;
  wire logic rd_mapped = hi_addr_zero_r && ((rd_ofs == `ACS_OFS_CMD) || (rd_ofs == `ACS_OFS_STATUS)
    || (rd_ofs == `ACS_OFS_DIAG) || (rd_ofs == `ACS_OFS_IRQ_STAT)
    || (rd_ofs == `ACS_OFS_IRQ_MASK));
  wire logic [31:0] status_word = {24'h000000, 1'b0, mode, feed_hold_lamp,
    cycle_running_lamp, state};

  // Read data selection
  wire logic [31:0] rd_word =
    !hi_addr_zero_r ? 32'h00000000 :
    (rd_ofs == `ACS_OFS_STATUS) ? status_word :
    (rd_ofs == `ACS_OFS_DIAG) ? {26'h0000000, diag} :
    (rd_ofs == `ACS_OFS_IRQ_STAT) ? {30'h00000000, irq_stat} :
    (rd_ofs == `ACS_OFS_IRQ_MASK) ? {30'h00000000, irq_mask} : 32'h00000000;

  // ****************************************
  // Stop causes
  // ****************************************
  wire logic start_req = wr_cmd && w_data[`ACS_CMD_START];
  wire logic key_reset = wr_cmd && w_data[`ACS_CMD_RESET_KEY];
  wire logic estop = !machine_in_byte[`ACS_SIG_ESTOP] || !ctrl_signal_byte[`ACS_SIG_ESTOP];
  wire logic ext_reset = ctrl_signal_byte[`ACS_SIG_EXT_RESET];
  wire logic rewind_req = ctrl_signal_byte[`ACS_SIG_RESET_REWIND];
  wire logic mode_drop = prev_auto && !mode_auto;
  wire logic hold_in = !ctrl_signal_byte[`ACS_SIG_FEED_HOLD];
  wire logic any_reset = estop || ext_reset || rewind_req || key_reset || servo_alarm;
  wire logic any_hold = mode_drop || hold_in;
  wire logic sb_stop = ctrl_signal_byte[`ACS_SIG_SINGLE_BLOCK] && block_done;
  wire logic running = (state == acs_pkg::ACS_RUN);
  wire logic dropping = running && (next_state != acs_pkg::ACS_RUN);
  wire logic start_ok = start_req && mode_runs && !any_reset && !any_hold;
  // One cause per diagnostic entry, reset key sharing 021 with external reset, mode change sharing 024 with feed hold, 020 in bit 0 up to 025 in bit 5
  wire logic [`ACS_DIAG_W-1:0] cause_vec = {sb_stop && !any_reset && !any_hold,
    any_hold && !any_reset, servo_alarm, rewind_req, ext_reset || key_reset, estop};

  // ****************************************
  // Run state machine
  // ****************************************
  always_comb
  begin
    next_state = state;
    if (any_reset)
    begin
      next_state = acs_pkg::ACS_RESET;
    end
    else
    begin
      unique case (state)
        acs_pkg::ACS_RESET:
        begin
          if (start_ok)
          begin
            next_state = acs_pkg::ACS_RUN;
          end
        end
        acs_pkg::ACS_RUN:
        begin
          if (any_hold)
          begin
            next_state = acs_pkg::ACS_HOLD;
          end
          else if (sb_stop)
          begin
            next_state = acs_pkg::ACS_BLOCK_STOP;
          end
        end
        acs_pkg::ACS_HOLD, acs_pkg::ACS_BLOCK_STOP:
        begin
          if (start_ok)
          begin
            next_state = acs_pkg::ACS_RUN;
          end
        end
      endcase
    end
  end

  // State, lamps and rewind strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= acs_pkg::ACS_RESET;
      prev_auto <= 1'b0;
      cycle_running_lamp <= 1'b0;
      feed_hold_lamp <= 1'b0;
      program_rewind <= 1'b0;
    end
    else
    begin
      state <= next_state;
      prev_auto <= mode_auto;
      cycle_running_lamp <= (next_state == acs_pkg::ACS_RUN);
      feed_hold_lamp <= (next_state == acs_pkg::ACS_HOLD);
      program_rewind <= rewind_req;
    end
  end

  // Drop cause latched at the drop, cleared at the next start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      diag <= `ACS_RST_DIAG;
    end
    else if (dropping)
    begin
      diag <= cause_vec;
    end
    else if (start_ok)
    begin
      diag <= `ACS_RST_DIAG;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire logic [`ACS_IRQ_W-1:0] irq_set = {rewind_req, dropping};
  wire logic [`ACS_IRQ_W-1:0] irq_clr = wr_irq_stat ? w_data[`ACS_IRQ_W-1:0] : '0;

  // Sticky status, set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat <= `ACS_RST_IRQ;
      irq_mask <= `ACS_RST_IRQ;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq_mask <= wr_irq_mask ? w_data[`ACS_IRQ_W-1:0] : irq_mask;
      irq <= |(((irq_stat & ~irq_clr) | irq_set) & (wr_irq_mask ? w_data[`ACS_IRQ_W-1:0]
        : irq_mask));
    end
  end

  // ****************************************
  // AXI4-Lite write and read channels
  // ****************************************
  wire logic next_aw_held = wr_fire ? 1'b0 : (aw_held || (s_axi_awvalid && s_axi_awready));
  wire logic next_w_held = wr_fire ? 1'b0 : (w_held || (s_axi_wvalid && s_axi_wready));
  wire logic next_bvalid = wr_fire || (s_axi_bvalid && !s_axi_bready);
  wire logic next_rvalid = rd_fire || (s_axi_rvalid && !s_axi_rready);

  // Address and data capture, response generation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACS_RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !next_aw_held && !next_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !next_w_held && !next_bvalid && !(s_axi_wvalid && s_axi_wready);
      s_axi_bvalid <= next_bvalid;
      if (wr_fire)
      begin
        s_axi_bresp <= (wr_mapped && hi_addr_zero_w) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ACS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid && !rd_fire;
      s_axi_rvalid <= next_rvalid;
      if (rd_fire)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_run_with_reset;
    running && any_reset;
  endsequence

  sequence s_lamp_dark;
    !cycle_running_lamp && (state == acs_pkg::ACS_RESET);
  endsequence

  property p_drop_latches_cause;
    @(posedge aclk) disable iff (!aresetn)
      dropping |=> (diag == $past(cause_vec)) && (diag != '0);
  endproperty
  a_drop_latches_cause: assert property (p_drop_latches_cause)
    else $error("drop cause not latched");

  property p_estop_resets;
    @(posedge aclk) disable iff (!aresetn)
      !machine_in_byte[`ACS_SIG_ESTOP] |=> s_lamp_dark;
  endproperty
  a_estop_resets: assert property (p_estop_resets)
    else $error("emergency stop did not reset");

  property p_ext_reset;
    @(posedge aclk) disable iff (!aresetn)
      (running && ext_reset) |=> s_lamp_dark ##1 !cycle_running_lamp;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("external reset did not end operation");

  property p_rewind;
    @(posedge aclk) disable iff (!aresetn)
      rewind_req |=> program_rewind && (state == acs_pkg::ACS_RESET) && irq_stat[`ACS_IRQ_REWIND];
  endproperty
  a_rewind: assert property (p_rewind)
    else $error("rewind request not served");

  property p_key_reset;
    @(posedge aclk) disable iff (!aresetn)
      key_reset |=> s_lamp_dark;
  endproperty
  a_key_reset: assert property (p_key_reset)
    else $error("reset key ignored");

  property p_servo_alarm;
    @(posedge aclk) disable iff (!aresetn)
      (servo_alarm && running) |=> s_lamp_dark and diag[3];
  endproperty
  a_servo_alarm: assert property (p_servo_alarm)
    else $error("servo alarm did not reset");

  property p_mode_hold;
    @(posedge aclk) disable iff (!aresetn)
      (running && mode_drop && !any_reset) |=> feed_hold_lamp && !cycle_running_lamp;
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode change did not hold");

  property p_feed_hold;
    @(posedge aclk) disable iff (!aresetn)
      (running && hold_in && !any_reset) |=> (state == acs_pkg::ACS_HOLD) && feed_hold_lamp;
  endproperty
  a_feed_hold: assert property (p_feed_hold)
    else $error("feed hold not entered");

  property p_mode_decode;
    @(posedge aclk) disable iff (!aresetn)
      (mode_bits == 3'h1) |-> (mode == acs_pkg::ACS_MODE_AUTO) && mode_runs;
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("memory mode decoded wrongly");

  property p_single_block;
    @(posedge aclk) disable iff (!aresetn)
      (running && sb_stop && !any_reset && !any_hold) |=>
        (state == acs_pkg::ACS_BLOCK_STOP) && !cycle_running_lamp && diag[5];
  endproperty
  a_single_block: assert property (p_single_block)
    else $error("single block did not stop");

  property p_lamp_tracks_run;
    @(posedge aclk) disable iff (!aresetn)
      (cycle_running_lamp == running)
        && !(cycle_running_lamp && ($past(any_reset) || $past(any_hold)));
  endproperty
  a_lamp_tracks_run: assert property (p_lamp_tracks_run)
    else $error("lamp disagrees with run state");

  property p_reset_first;
    @(posedge aclk) disable iff (!aresetn)
      s_run_with_reset ##0 any_hold |=> !feed_hold_lamp && (state == acs_pkg::ACS_RESET);
  endproperty
  a_reset_first: assert property (p_reset_first)
    else $error("hold won over reset");

endmodule // acs_top

// *** tb/acs_plc_model.sv ***
// Machine-side controller model driving the controller signal byte
`timescale 1ns/1ps
module acs_plc_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] base_byte,
  input wire logic [1:0] prog_end,
  input wire logic [1:0] ack_dly,
  output logic [7:0] ctrl_signal_byte
);
  logic [2:0] cnt;
  logic [1:0] kind;
  logic act;

  // Program end seen: wait a while, then acknowledge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 3'h0;
      kind <= 2'h0;
    end
    else if (prog_end != 2'h0)
    begin
      cnt <= {1'b0, ack_dly} + 3'h3;
      kind <= prog_end;
    end
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end

  // Request stands two cycles at the end of the wait
  assign act = (cnt != 3'h0) && (cnt <= 3'h2);
  // External reset answers M02, rewind answers M30
  assign ctrl_signal_byte = base_byte | {act && kind[0], act && kind[1], 6'h00};
endmodule // acs_plc_model

// *** tb/acs_top_tb_top.sv ***
// Self-checking bench of the automatic cycle run/stop controller
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_top_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, mach = 8'h10, base = 8'h30, ctrl;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd, rnd;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, lamp, hold_lamp, rewind, irq;
  logic [1:0] bresp, rresp, r, pend = 2'h0, dly = 2'h0;
  logic [2:0] mode = 3'h1;
  logic servo = 1'b0, blk = 1'b0;
  int error_cnt = 0, total_checks = 0, cyc = 0, seed = 32'h290f;

  always #5 aclk = ~aclk;

  acs_plc_model plc (.aclk(aclk), .aresetn(aresetn), .base_byte(base), .prog_end(pend),
    .ack_dly(dly), .ctrl_signal_byte(ctrl));

  acs_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .machine_in_byte(mach), .ctrl_signal_byte(ctrl), .mode_sel_high(mode[2]),
    .mode_sel_mid(mode[1]), .mode_sel_low(mode[0]), .servo_alarm(servo), .block_done(blk),
    .cycle_running_lamp(lamp), .feed_hold_lamp(hold_lamp), .program_rewind(rewind), .irq(irq));

  // ****************************************
  // Checking, bus tasks and expectations
  // ****************************************
  task summarize;
  begin
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  // Write: address and data together, bready held until bvalid
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] res);
    int n;
  begin
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        res = bresp;
        bready <= 1'b0;
        break;
      end
    end
    check(32'(n < 64), 32'h1);
  end
  endtask

  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] res);
    int n;
  begin
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        res = rresp;
        d = rdata;
        rready <= 1'b0;
        break;
      end
    end
    check(32'(n < 64), 32'h1);
  end
  endtask

  task wait_lamp(input logic v);
  begin
    for (int n = 0; n < 6; n++)
    begin
      @(posedge aclk);
      #1;
      if (lamp === v)
        break;
    end
    check({31'h0, lamp}, {31'h0, v});
  end
  endtask

  function automatic logic [5:0] exp_diag(input int k);
    case (k)
      0, 1: return 6'h01;
      4, 10: return 6'h04;
      5: return 6'h08;
      6, 7: return 6'h10;
      8: return 6'h20;
      default: return 6'h02;
    endcase
  endfunction

  function automatic logic [1:0] exp_state(input int k);
    return (k == 6 || k == 7) ? 2'h2 : ((k == 8) ? 2'h3 : 2'h0);
  endfunction

  function automatic acs_pkg::acs_mode_t exp_mode(input logic [2:0] m);
    case (m)
      3'h0: return acs_pkg::ACS_MODE_MDI;
      3'h1: return acs_pkg::ACS_MODE_AUTO;
      3'h3: return acs_pkg::ACS_MODE_EDIT;
      3'h4: return acs_pkg::ACS_MODE_JOG;
      3'h5: return acs_pkg::ACS_MODE_HANDLE;
      3'h6: return acs_pkg::ACS_MODE_TEACH_JOG;
      default: return acs_pkg::ACS_MODE_TEACH_HANDLE;
    endcase
  endfunction

  // Run from start to one stop cause (external reset with feed hold for 11 and 12), then check cause and state
  task run_stop(input int k);
  begin
    @(posedge aclk);
    base <= 8'h30 | (8'($random(seed)) & 8'h0D);
    mach <= 8'h10 | (8'($random(seed)) & 8'hEF);
    mode <= 3'h1;
    servo <= 1'b0;
    dly <= 2'($random(seed));
    axw(`ACS_OFS_IRQ_STAT, 32'h3, r);
    axw(`ACS_OFS_CMD, 32'h1, r);
    wait_lamp(1'b1);
    repeat (1 + ($unsigned($random(seed)) % 8)) @(posedge aclk);
    case (k)
      0: mach[4] <= 1'b0;
      1: base[4] <= 1'b0;
      2: base[7] <= 1'b1;
      3: axw(`ACS_OFS_CMD, 32'h2, r);
      4: base[6] <= 1'b1;
      5: servo <= 1'b1;
      6: base[5] <= 1'b0;
      7: mode <= 3'h4;
      8: base[1] <= 1'b1;
      9: pend <= 2'h1;
      10: pend <= 2'h2;
      default: base <= 8'h90;
    endcase
    @(posedge aclk);
    pend <= 2'h0;
    blk <= (k == 8);
    @(posedge aclk);
    blk <= 1'b0;
    wait_lamp(1'b0);
    check({31'h0, irq}, (k < 12) ? 32'h1 : 32'h0);
    axr(`ACS_OFS_STATUS, rd, r);
    check({30'h0, rd[1:0]}, {30'h0, exp_state(k)});
    check({31'h0, hold_lamp}, {31'h0, (k == 6) || (k == 7)});
    axr(`ACS_OFS_DIAG, rd, r);
    check({26'h0, rd[5:0] & ((k == 11) ? 6'h0F : 6'h3F)}, {26'h0, exp_diag(k)});
    if (k == 4)
      check({31'h0, rewind}, 32'h1);
    $display("test %0d done", k);
  end
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(`ACS_OFS_DIAG, rd, r);
    check(rd, 32'h0);
    axr(`ACS_OFS_IRQ_MASK, rd, r);
    check(rd, 32'h0);
    repeat (4)
    begin
      rnd = $random(seed);
      axw(`ACS_OFS_IRQ_MASK, rnd, r);
      check({30'h0, r}, {30'h0, `ACS_RESP_OKAY});
      axr(`ACS_OFS_IRQ_MASK, rd, r);
      check(rd, rnd & 32'h3);
    end
    axr(8'h20, rd, r);
    check(rd, 32'h0);
    check({30'h0, r}, {30'h0, `ACS_RESP_SLVERR});
    axw(8'h24, 32'h1, r);
    check({30'h0, r}, {30'h0, `ACS_RESP_SLVERR});
    $display("test registers done");
    for (int m = 0; m < 8; m++)
      if (m != 2)
      begin
        @(posedge aclk);
        mode <= 3'(m);
        axr(`ACS_OFS_STATUS, rd, r);
        check({29'h0, rd[6:4]}, {29'h0, exp_mode(3'(m))});
      end
    $display("test modes done");
    axw(`ACS_OFS_IRQ_MASK, 32'h1, r);
    for (int k = 0; k < 12; k++)
      run_stop(k);
    axw(`ACS_OFS_IRQ_MASK, 32'h0, r);
    run_stop(12);
    summarize();
  end
endmodule // acs_top_tb_top
